// ==== shared/hsil_pkg.sv ====
// shared constants and types for the haptic status and event latch block
package hsil_pkg;
    // register offsets
    localparam logic [7:0] OFS_SOFT_RESET = 8'h00;
    localparam logic [7:0] OFS_LIVE_STATUS = 8'h01;
    localparam logic [7:0] OFS_LATCHED = 8'h02;
    localparam logic [7:0] OFS_PIN_MASKS = 8'h03;
    localparam logic [7:0] OFS_SYSTEM_CONTROL_TWO = 8'h44;
    localparam logic [7:0] OFS_SYSTEM_CONTROL_SEVEN = 8'h49;
    localparam logic [7:0] OFS_PWM1 = 8'h4C;
    localparam logic [7:0] OFS_PWM2 = 8'h4D;
    localparam logic [7:0] OFS_PWM3 = 8'h4E;
    localparam logic [7:0] OFS_PWM4 = 8'h4F;
    localparam logic [7:0] OFS_DET1 = 8'h51;
    localparam logic [7:0] OFS_DET2 = 8'h52;
    localparam logic [7:0] OFS_LOAD_RESISTANCE_RESULT = 8'h53;
    localparam logic [7:0] OFS_BATTERY_VOLTAGE_RESULT = 8'h55;
    localparam logic [7:0] OFS_DET_LOW = 8'h57;
    localparam logic [7:0] OFS_TRIM = 8'h5A;
    localparam logic [7:0] OFS_PART_ID = 8'h64;
    localparam logic [7:0] OFS_ANA8 = 8'h77;
    // soft reset key
    localparam logic [7:0] SOFT_RESET_KEY = 8'hAA;
    // number of event sources and their reset values
    localparam int NUM_EVENTS = 6;
    localparam logic [5:0] LATCH_RST = 6'h10;
    localparam logic [5:0] MASK_RST = 6'h3F;
    // configuration reset values
    localparam logic [7:0] RST_SYSTEM_CONTROL_TWO = 8'h28;
    localparam logic [7:0] RST_SYSTEM_CONTROL_SEVEN = 8'h14;
    localparam logic [7:0] RST_PWM1 = 8'hA0;
    localparam logic [7:0] RST_PWM2 = 8'h28;
    localparam logic [7:0] RST_PWM3 = 8'hBF;
    localparam logic [7:0] RST_PWM4 = 8'h32;
    localparam logic [7:0] RST_DET1 = 8'h02;
    localparam logic [7:0] RST_DET2 = 8'h00;
    localparam logic [7:0] RST_TRIM = 8'h00;
    localparam logic [7:0] RST_ANA8 = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [1:0] ZERO_PAD = 2'h0;
    // part identification, arbitrary neutral value
    localparam logic [7:0] PART_ID_DEFAULT = 8'h5C;

    // live condition flags, bit order 5..0 as in the status register
    typedef struct packed {
        logic undervoltage_live;
        logic fifo_nearly_empty_live;
        logic fifo_nearly_full_live;
        logic overcurrent_live;
        logic overtemp_live;
        logic playback_finished_live;
    } hsil_cond_t;

    // register access request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } hsil_req_t;

    // measurement results fed from the analog side
    typedef struct packed {
        logic [7:0] load_res;
        logic [7:0] vbat;
        logic [7:0] low_bits;
    } hsil_meas_t;

    // configuration register set
    typedef struct packed {
        logic [7:0] system_control_two;
        logic [7:0] system_control_seven;
        logic [7:0] pwm1;
        logic [7:0] pwm2;
        logic [7:0] pwm3;
        logic [7:0] pwm4;
        logic [7:0] det1;
        logic [7:0] det2;
        logic [7:0] trim;
        logic [7:0] ana8;
    } hsil_cfg_t;

    // whole block state
    typedef struct packed {
        hsil_cond_t live_s1;
        hsil_cond_t live_s2;
        logic [5:0] latch;
        logic [5:0] mask;
        hsil_cfg_t cfg;
        logic [7:0] rdata;
        logic rvalid;
        logic pin_oe;
    } hsil_state_t;
endpackage

// ==== rtl/hsil_status_irq.sv ====
// status, latched event flags, pin masks and configuration registers
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - writing 0xAA restores configuration defaults
// - status bit 5 shows live undervoltage
// - status bit 4 shows fifo nearly empty
// - status bit 2 shows live overcurrent
// - status bit 1 shows live overtemperature
// - latch bit 5 catches undervoltage since read
// - latch bit 4 catches nearly empty, resets one
// - latch bit 3 catches fifo nearly full
// - latch bit 2 catches overcurrent since read
// - latch bit 1 catches overtemperature since read
// - latch bit 0 catches playback finished
// - reading latch register clears all bits whose live flag is low
// - mask bit 5 gates undervoltage onto pin
// - mask bit 4 gates nearly empty onto pin
// - mask bit 3 gates nearly full onto pin
// - mask bits 2..0 gate remaining latches
//////////////////////////////////////////////////////////////////////////////
module hsil_status_irq #(
    parameter logic [7:0] PART_ID = hsil_pkg::PART_ID_DEFAULT
) (
    input wire logic mclk_in,
    input wire logic rst_b_in,
    input wire hsil_pkg::hsil_req_t req_in,
    input wire hsil_pkg::hsil_cond_t cond_in,
    input wire hsil_pkg::hsil_meas_t meas_in,
    output logic [7:0] rdata_out,
    output logic rvalid_out,
    output logic event_request_pin_n_out,
    output logic event_request_pin_n_oe_out,
    output hsil_pkg::hsil_cfg_t cfg_out
);
    import hsil_pkg::*;

    hsil_state_t state_q;
    hsil_state_t state_d;
    hsil_cfg_t cfg_rst;
    logic [5:0] live_vec;
    logic [5:0] pending;

    //////////////////////////////////////////////////////////////////////////
    // reset images and helper views
    always_comb begin
        cfg_rst = '{system_control_two: RST_SYSTEM_CONTROL_TWO, system_control_seven: RST_SYSTEM_CONTROL_SEVEN,
                    pwm1: RST_PWM1, pwm2: RST_PWM2, pwm3: RST_PWM3,
                    pwm4: RST_PWM4, det1: RST_DET1, det2: RST_DET2,
                    trim: RST_TRIM, ana8: RST_ANA8};
        live_vec = state_q.live_s2;
        pending = state_q.latch & ~state_q.mask;
    end

    //////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        state_d = state_q;
        state_d.rvalid = 1'b0;
        // two-stage synchroniser on the live condition pins
        state_d.live_s1 = cond_in;
        state_d.live_s2 = state_q.live_s1;
        // read clears, but a live event in the same cycle wins
        if (req_in.rd && req_in.addr == OFS_LATCHED) begin
            state_d.latch = live_vec;
        end else begin
            state_d.latch = state_q.latch | live_vec;
        end
        // register writes; reserved bits of the mask stay zero
        if (req_in.wr) begin
            if (req_in.addr == OFS_SOFT_RESET) begin
                if (req_in.wdata == SOFT_RESET_KEY) begin
                    state_d.cfg = cfg_rst;
                    state_d.mask = MASK_RST;
                end
            end else if (req_in.addr == OFS_PIN_MASKS) begin
                state_d.mask = req_in.wdata[5:0];
            end else if (req_in.addr == OFS_SYSTEM_CONTROL_TWO) begin
                state_d.cfg.system_control_two = req_in.wdata;
            end else if (req_in.addr == OFS_SYSTEM_CONTROL_SEVEN) begin
                state_d.cfg.system_control_seven = req_in.wdata;
            end else if (req_in.addr == OFS_PWM1) begin
                state_d.cfg.pwm1 = req_in.wdata;
            end else if (req_in.addr == OFS_PWM2) begin
                state_d.cfg.pwm2 = req_in.wdata;
            end else if (req_in.addr == OFS_PWM3) begin
                state_d.cfg.pwm3 = req_in.wdata;
            end else if (req_in.addr == OFS_PWM4) begin
                state_d.cfg.pwm4 = req_in.wdata;
            end else if (req_in.addr == OFS_DET1) begin
                state_d.cfg.det1 = req_in.wdata;
            end else if (req_in.addr == OFS_DET2) begin
                state_d.cfg.det2 = req_in.wdata;
            end else if (req_in.addr == OFS_TRIM) begin
                state_d.cfg.trim = req_in.wdata;
            end else if (req_in.addr == OFS_ANA8) begin
                state_d.cfg.ana8 = req_in.wdata;
            end
        end
        // read data path; unmapped and write-only addresses read zero
        if (req_in.rd) begin
            state_d.rvalid = 1'b1;
            if (req_in.addr == OFS_LIVE_STATUS) begin
                state_d.rdata = {ZERO_PAD, live_vec};
            end else if (req_in.addr == OFS_LATCHED) begin
                state_d.rdata = {ZERO_PAD, state_q.latch};
            end else if (req_in.addr == OFS_PIN_MASKS) begin
                state_d.rdata = {ZERO_PAD, state_q.mask};
            end else if (req_in.addr == OFS_SYSTEM_CONTROL_TWO) begin
                state_d.rdata = state_q.cfg.system_control_two;
            end else if (req_in.addr == OFS_SYSTEM_CONTROL_SEVEN) begin
                state_d.rdata = state_q.cfg.system_control_seven;
            end else if (req_in.addr == OFS_PWM1) begin
                state_d.rdata = state_q.cfg.pwm1;
            end else if (req_in.addr == OFS_PWM2) begin
                state_d.rdata = state_q.cfg.pwm2;
            end else if (req_in.addr == OFS_PWM3) begin
                state_d.rdata = state_q.cfg.pwm3;
            end else if (req_in.addr == OFS_PWM4) begin
                state_d.rdata = state_q.cfg.pwm4;
            end else if (req_in.addr == OFS_DET1) begin
                state_d.rdata = state_q.cfg.det1;
            end else if (req_in.addr == OFS_DET2) begin
                state_d.rdata = state_q.cfg.det2;
            end else if (req_in.addr == OFS_LOAD_RESISTANCE_RESULT) begin
                state_d.rdata = meas_in.load_res;
            end else if (req_in.addr == OFS_BATTERY_VOLTAGE_RESULT) begin
                state_d.rdata = meas_in.vbat;
            end else if (req_in.addr == OFS_DET_LOW) begin
                state_d.rdata = meas_in.low_bits;
            end else if (req_in.addr == OFS_TRIM) begin
                state_d.rdata = state_q.cfg.trim;
            end else if (req_in.addr == OFS_PART_ID) begin
                state_d.rdata = PART_ID;
            end else if (req_in.addr == OFS_ANA8) begin
                state_d.rdata = state_q.cfg.ana8;
            end else begin
                state_d.rdata = ZERO_BYTE;
            end
        end
        // pull the pin low while any unmasked latch is set
        state_d.pin_oe = |(state_d.latch & ~state_d.mask);
    end

    //////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            // status view starts with nearly empty set, as the latch does
            state_q.live_s1 <= hsil_cond_t'(LATCH_RST);
            state_q.live_s2 <= hsil_cond_t'(LATCH_RST);
            state_q.latch <= LATCH_RST;
            state_q.mask <= MASK_RST;
            state_q.cfg <= '{system_control_two: RST_SYSTEM_CONTROL_TWO, system_control_seven: RST_SYSTEM_CONTROL_SEVEN,
                             pwm1: RST_PWM1, pwm2: RST_PWM2, pwm3: RST_PWM3,
                             pwm4: RST_PWM4, det1: RST_DET1,
                             det2: RST_DET2, trim: RST_TRIM,
                             ana8: RST_ANA8};
            state_q.rdata <= ZERO_BYTE;
            state_q.rvalid <= 1'b0;
            state_q.pin_oe <= 1'b0;
        end else begin
            state_q <= state_d;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // outputs straight from flip-flops; the pin only ever drives low
    always_comb begin
        rdata_out = state_q.rdata;
        rvalid_out = state_q.rvalid;
        event_request_pin_n_out = 1'b0;
        event_request_pin_n_oe_out = state_q.pin_oe;
        cfg_out = state_q.cfg;
    end

    //////////////////////////////////////////////////////////////////////////
    // checks
    a_latch_catches: assert property (@(posedge mclk_in)
        disable iff (!rst_b_in)
        state_q.live_s2.undervoltage_live |=> state_q.latch[5])
        else $error("undervoltage event not latched");
    a_read_clears: assert property (@(posedge mclk_in)
        disable iff (!rst_b_in)
        (req_in.rd && req_in.addr == OFS_LATCHED && !req_in.wr)
        |=> (state_q.latch == $past(live_vec)))
        else $error("latch read did not clear");
    a_set_beats_clear: assert property (@(posedge mclk_in)
        disable iff (!rst_b_in)
        (req_in.rd && req_in.addr == OFS_LATCHED && live_vec[2])
        |=> state_q.latch[2])
        else $error("event lost on clearing read");
    a_pin_follows: assert property (@(posedge mclk_in)
        disable iff (!rst_b_in)
        event_request_pin_n_oe_out == |pending)
        else $error("pin enable mismatch");
    a_status_read: assert property (@(posedge mclk_in)
        disable iff (!rst_b_in)
        (req_in.rd && req_in.addr == OFS_LIVE_STATUS)
        |=> rvalid_out && rdata_out == {ZERO_PAD, $past(live_vec)})
        else $error("status read wrong");
    a_soft_reset: assert property (@(posedge mclk_in)
        disable iff (!rst_b_in)
        (req_in.wr && req_in.addr == OFS_SOFT_RESET
         && req_in.wdata == SOFT_RESET_KEY)
        |=> cfg_out == cfg_rst && state_q.mask == MASK_RST)
        else $error("soft reset did not restore defaults");
    a_mask_write: assert property (@(posedge mclk_in)
        disable iff (!rst_b_in)
        (req_in.wr && req_in.addr == OFS_PIN_MASKS)
        |=> state_q.mask == $past(req_in.wdata[5:0]))
        else $error("mask write lost");
    a_part_id: assert property (@(posedge mclk_in)
        disable iff (!rst_b_in)
        (req_in.rd && req_in.addr == OFS_PART_ID)
        |=> rdata_out == PART_ID)
        else $error("part id wrong");
    a_live_to_status: assert property (@(posedge mclk_in)
        disable iff (!rst_b_in)
        cond_in.overcurrent_live ##1 cond_in.overcurrent_live
        |=> live_vec[2])
        else $error("overcurrent status not shown");

    // each remaining source lands in its own latch bit
    a_empty_catches: assert property (@(posedge mclk_in)
        disable iff (!rst_b_in)
        state_q.live_s2.fifo_nearly_empty_live |=> state_q.latch[4])
        else $error("nearly empty event not latched");

    a_full_catches: assert property (@(posedge mclk_in)
        disable iff (!rst_b_in)
        state_q.live_s2.fifo_nearly_full_live |=> state_q.latch[3])
        else $error("nearly full event not latched");

    a_overcur_catches: assert property (@(posedge mclk_in)
        disable iff (!rst_b_in)
        state_q.live_s2.overcurrent_live |=> state_q.latch[2])
        else $error("overcurrent event not latched");

    a_overtemp_catches: assert property (@(posedge mclk_in)
        disable iff (!rst_b_in)
        state_q.live_s2.overtemp_live |=> state_q.latch[1])
        else $error("overtemperature event not latched");

    a_done_catches: assert property (@(posedge mclk_in)
        disable iff (!rst_b_in)
        state_q.live_s2.playback_finished_live |=> state_q.latch[0])
        else $error("playback finished event not latched");

    // a pin level held two cycles shows in the status view
    a_uv_status: assert property (@(posedge mclk_in)
        disable iff (!rst_b_in)
        cond_in.undervoltage_live ##1 cond_in.undervoltage_live
        |=> live_vec[5])
        else $error("undervoltage status not shown");

    a_empty_status: assert property (@(posedge mclk_in)
        disable iff (!rst_b_in)
        cond_in.fifo_nearly_empty_live ##1 cond_in.fifo_nearly_empty_live
        |=> live_vec[4])
        else $error("nearly empty status not shown");

    a_overtemp_status: assert property (@(posedge mclk_in)
        disable iff (!rst_b_in)
        cond_in.overtemp_live ##1 cond_in.overtemp_live
        |=> live_vec[1])
        else $error("overtemperature status not shown");

    // an unmasked latch always pulls the pin
    a_mask_uv: assert property (@(posedge mclk_in)
        disable iff (!rst_b_in)
        state_q.latch[5] && !state_q.mask[5] |-> event_request_pin_n_oe_out)
        else $error("unmasked undervoltage left pin released");

    a_mask_empty: assert property (@(posedge mclk_in)
        disable iff (!rst_b_in)
        state_q.latch[4] && !state_q.mask[4] |-> event_request_pin_n_oe_out)
        else $error("unmasked nearly empty left pin released");

    a_mask_full: assert property (@(posedge mclk_in)
        disable iff (!rst_b_in)
        state_q.latch[3] && !state_q.mask[3] |-> event_request_pin_n_oe_out)
        else $error("unmasked nearly full left pin released");

    a_mask_rest: assert property (@(posedge mclk_in)
        disable iff (!rst_b_in)
        |(state_q.latch[2:0] & ~state_q.mask[2:0])
        |-> event_request_pin_n_oe_out)
        else $error("unmasked fault or done left pin released");

    // the pad only ever sinks; released means high impedance
    a_pin_drive: assert property (@(posedge mclk_in)
        disable iff (!rst_b_in)
        event_request_pin_n_oe_out |-> !event_request_pin_n_out)
        else $error("pin driven high");

    // reset image of the whole register set
    a_reset_image: assert property (@(posedge mclk_in)
        !rst_b_in |=> state_q.latch == LATCH_RST
        && state_q.mask == MASK_RST && state_q.live_s2 == LATCH_RST
        && cfg_out == cfg_rst && !event_request_pin_n_oe_out)
        else $error("reset values wrong");

    // a soft reset write with any other value changes nothing
    a_wrong_key: assert property (@(posedge mclk_in)
        disable iff (!rst_b_in)
        (req_in.wr && req_in.addr == OFS_SOFT_RESET
         && req_in.wdata != SOFT_RESET_KEY)
        |=> $stable(cfg_out) && $stable(state_q.mask))
        else $error("soft reset took a wrong key");

    // the identification byte is read-only
    a_part_id_ro: assert property (@(posedge mclk_in)
        disable iff (!rst_b_in)
        (req_in.wr && req_in.addr == OFS_PART_ID)
        |=> $stable(cfg_out) && $stable(state_q.mask))
        else $error("write to part id changed a register");

    // read data of the latch and mask registers
    a_latch_readback: assert property (@(posedge mclk_in)
        disable iff (!rst_b_in)
        (req_in.rd && req_in.addr == OFS_LATCHED)
        |=> rdata_out == {ZERO_PAD, $past(state_q.latch)})
        else $error("latch read data wrong");

    a_mask_readback: assert property (@(posedge mclk_in)
        disable iff (!rst_b_in)
        (req_in.rd && req_in.addr == OFS_PIN_MASKS)
        |=> rdata_out == {ZERO_PAD, $past(state_q.mask)})
        else $error("mask read data wrong");

    // a live flag during the clearing read keeps its latch bit
    a_keep_uv: assert property (@(posedge mclk_in)
        disable iff (!rst_b_in)
        (req_in.rd && req_in.addr == OFS_LATCHED && live_vec[5])
        |=> state_q.latch[5])
        else $error("undervoltage lost on clearing read");

    a_keep_empty: assert property (@(posedge mclk_in)
        disable iff (!rst_b_in)
        (req_in.rd && req_in.addr == OFS_LATCHED && live_vec[4])
        |=> state_q.latch[4])
        else $error("nearly empty lost on clearing read");

    a_keep_full: assert property (@(posedge mclk_in)
        disable iff (!rst_b_in)
        (req_in.rd && req_in.addr == OFS_LATCHED && live_vec[3])
        |=> state_q.latch[3])
        else $error("nearly full lost on clearing read");

    a_keep_overtemp: assert property (@(posedge mclk_in)
        disable iff (!rst_b_in)
        (req_in.rd && req_in.addr == OFS_LATCHED && live_vec[1])
        |=> state_q.latch[1])
        else $error("overtemperature lost on clearing read");

    a_keep_done: assert property (@(posedge mclk_in)
        disable iff (!rst_b_in)
        (req_in.rd && req_in.addr == OFS_LATCHED && live_vec[0])
        |=> state_q.latch[0])
        else $error("playback finished lost on clearing read");

    // covers of the main scenarios
    c_pin_asserted: cover property (@(posedge mclk_in)
        disable iff (!rst_b_in) $rose(event_request_pin_n_oe_out));
    c_clear_read: cover property (@(posedge mclk_in)
        disable iff (!rst_b_in)
        req_in.rd && req_in.addr == OFS_LATCHED && |state_q.latch);
    c_soft_reset: cover property (@(posedge mclk_in)
        disable iff (!rst_b_in)
        req_in.wr && req_in.addr == OFS_SOFT_RESET
        && req_in.wdata == SOFT_RESET_KEY);

    // covers: an event held over its clearing read, a masked pending latch
    c_event_kept: cover property (@(posedge mclk_in)
        disable iff (!rst_b_in)
        req_in.rd && req_in.addr == OFS_LATCHED && |live_vec);
    c_masked_pending: cover property (@(posedge mclk_in)
        disable iff (!rst_b_in)
        |(state_q.latch & state_q.mask) && !event_request_pin_n_oe_out);
endmodule

// ==== tb/hsil_host_model.sv ====
// host side model: register strobes and the pulled-up event line
`timescale 1ns/1ps
module hsil_host_model (
    input wire logic mclk_in,
    input wire logic [7:0] rdata_in,
    input wire logic rvalid_in,
    input wire logic pin_n_in,
    input wire logic pin_oe_in,
    output hsil_pkg::hsil_req_t req_out,
    output logic line_out
);
    import hsil_pkg::*;
    //////////////////////////////////////////////////////////////////////
    // open-drain line, the pull-up wins while nobody drives it
    assign line_out = pin_oe_in ? pin_n_in : 1'b1;
    initial begin
        req_out = '0;
    end
    //////////////////////////////////////////////////////////////////////
    // one write strobe; released fields show the inverse, not stale data
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk_in);
        req_out = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge mclk_in);
        req_out = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
    // one read strobe, data taken in the cycle the answer stands
    task automatic read(input logic [7:0] a, output logic [7:0] d,
                        output logic v);
        @(negedge mclk_in);
        req_out = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge mclk_in);
        d = rdata_in;
        v = rvalid_in;
        req_out = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
    endtask
endmodule

// ==== tb/tb_haptic_status_interrupt_logic.sv ====
// self-checking bench for the status and event latch block
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin \
    err_count++; $display("[ERR] %s exp %h got %h", nm, ex, gt); end end
module tb_haptic_status_interrupt_logic;
    import hsil_pkg::*;
    logic mclk_in, rst_b_in, rdata_v, oe, pin_n, line;
    logic [7:0] rdata;
    hsil_req_t req;
    hsil_cond_t cond_in;
    hsil_meas_t meas_in;
    hsil_cfg_t cfg;
    int err_count = 0, num_checks = 0, cycles = 0;
    logic [31:0] seed = 32'h0000005C;
    logic [7:0] d, v8, vals [10];
    logic v;
    hsil_cfg_t exp_cfg;
    logic [7:0] ofs [10] = '{OFS_SYSTEM_CONTROL_TWO, OFS_SYSTEM_CONTROL_SEVEN, OFS_PWM1, OFS_PWM2,
        OFS_PWM3, OFS_PWM4, OFS_DET1, OFS_DET2, OFS_TRIM, OFS_ANA8};
    logic [7:0] dflt [10] = '{RST_SYSTEM_CONTROL_TWO, RST_SYSTEM_CONTROL_SEVEN, RST_PWM1,
        RST_PWM2, RST_PWM3, RST_PWM4, RST_DET1, RST_DET2, RST_TRIM, RST_ANA8};
    hsil_cfg_t def_cfg = '{RST_SYSTEM_CONTROL_TWO, RST_SYSTEM_CONTROL_SEVEN, RST_PWM1, RST_PWM2,
        RST_PWM3, RST_PWM4, RST_DET1, RST_DET2, RST_TRIM, RST_ANA8};
    //////////////////////////////////////////////////////////////////////
    // design and host model
    hsil_status_irq dut (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
        .req_in(req), .cond_in(cond_in), .meas_in(meas_in),
        .rdata_out(rdata), .rvalid_out(rdata_v),
        .event_request_pin_n_out(pin_n),
        .event_request_pin_n_oe_out(oe), .cfg_out(cfg));
    hsil_host_model host (.mclk_in(mclk_in), .rdata_in(rdata),
        .rvalid_in(rdata_v), .pin_n_in(pin_n), .pin_oe_in(oe),
        .req_out(req), .line_out(line));
    //////////////////////////////////////////////////////////////////////
    // clock, cycle ceiling and helpers
    initial begin
        mclk_in = 1'b0;
        forever #2.5 mclk_in = ~mclk_in;
    end
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            test_done();
        end
    end
    function automatic logic [7:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk_in);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e,
                          input string nm);
        logic [7:0] q;
        logic ok;
        host.read(a, q, ok);
        `CHK("rvalid", 1'b1, ok)
        `CHK(nm, e, q)
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    //////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        rst_b_in = 1'b0;
        cond_in = 6'h10;
        meas_in = {xs(), xs(), xs()};
        cyc(2);
        rst_b_in = 1'b1;
        cyc(4);
        // reset values of every register except the part id
        rd_chk(OFS_LATCHED, 8'h10, "latch_rst");
        rd_chk(OFS_PIN_MASKS, 8'h3F, "mask_rst");
        rd_chk(OFS_LIVE_STATUS, 8'h10, "status_rst");
        for (int i = 0; i < 10; i++) rd_chk(ofs[i], dflt[i], "cfg_rst");
        `CHK("cfg_out", def_cfg, cfg)
        `CHK("line_idle", 1'b1, line)
        rd_chk(OFS_LOAD_RESISTANCE_RESULT, meas_in.load_res, "rl");
        rd_chk(OFS_BATTERY_VOLTAGE_RESULT, meas_in.vbat, "vbat");
        rd_chk(OFS_DET_LOW, meas_in.low_bits, "lo");
        $display("test reset done");
        // random live flags show in the status register
        for (int i = 0; i < 8; i++) begin
            v8 = xs();
            cond_in = hsil_cond_t'(v8[5:0]);
            cyc(4);
            rd_chk(OFS_LIVE_STATUS, {2'h0, cond_in}, "status");
        end
        cond_in = 6'h00;
        cyc(4);
        host.read(OFS_LATCHED, d, v);
        rd_chk(OFS_LATCHED, 8'h00, "latch_clr");
        $display("test status done");
        // each event alone: latch, unmasked pin pull-down, clear
        for (int i = 0; i < 6; i++) begin
            host.write(OFS_PIN_MASKS, 8'h3F & ~(8'h01 << i));
            cond_in = 6'h01 << i;
            cyc(2);
            cond_in = 6'h00;
            cyc(4);
            `CHK("line_low", 1'b0, line)
            rd_chk(OFS_LATCHED, 8'h01 << i, "latch_bit");
            `CHK("line_rel", 1'b1, line)
            rd_chk(OFS_LATCHED, 8'h00, "latch_read");
        end
        host.write(OFS_PIN_MASKS, 8'h3F);
        cond_in = 6'h3F;
        cyc(4);
        `CHK("line_masked", 1'b1, line)
        // a flag still high during the clearing read keeps its latch
        host.read(OFS_LATCHED, d, v);
        rd_chk(OFS_LATCHED, 8'h3F, "latch_hold");
        cond_in = 6'h00;
        cyc(4);
        host.read(OFS_LATCHED, d, v);
        $display("test events done");
        // configuration survives a wrong key, defaults return on the key
        host.write(OFS_PIN_MASKS, 8'h00);
        rd_chk(OFS_PIN_MASKS, 8'h00, "mask_wr");
        for (int i = 0; i < 10; i++) begin
            vals[i] = xs();
            host.write(ofs[i], vals[i]);
        end
        host.write(OFS_SOFT_RESET, 8'h55);
        exp_cfg = {vals[0], vals[1], vals[2], vals[3], vals[4],
            vals[5], vals[6], vals[7], vals[8], vals[9]};
        `CHK("cfg_out_keep", exp_cfg, cfg)
        for (int i = 0; i < 10; i++) rd_chk(ofs[i], vals[i], "cfg_keep");
        host.write(OFS_SOFT_RESET, SOFT_RESET_KEY);
        for (int i = 0; i < 10; i++) rd_chk(ofs[i], dflt[i], "cfg_def");
        `CHK("cfg_out_def", def_cfg, cfg)
        rd_chk(OFS_PIN_MASKS, 8'h3F, "mask_def");
        v8 = xs();
        host.write(OFS_PART_ID, v8);
        rd_chk(OFS_PART_ID, PART_ID_DEFAULT, "part_id");
        rd_chk(8'h7F, 8'h00, "unmapped");
        $display("test config done");
        test_done();
    end
endmodule
